//--- pkg/dtc_pkg.sv
// Constants, field layout and types for the D/A trigger control block.
// Assumes a single 20 MHz AHB-Lite clock domain and 32-bit data.
package dtc_pkg;

   // ==========================================================
   // Register map (byte addresses, one aligned word each)
   // ==========================================================
   localparam int unsigned DEC_W = 8;
   localparam logic [7:0] OFS_MODE_CONTROL = 8'h00;
   localparam logic [7:0] OFS_OUTPUT_VALUE = 8'h04;
   localparam logic [7:0] OFS_STATUS       = 8'h08;

   // ==========================================================
   // Fields and reset values
   // ==========================================================
   localparam int unsigned DATA_W           = 8;
   localparam int unsigned MODE_RT_BIT      = 0;
   localparam int unsigned MODE_CE_BIT      = 7;
   localparam logic [7:0]  MODE_WR_MASK     = 8'h81;
   localparam logic [7:0]  MODE_RESET       = 8'h00;
   localparam logic [7:0]  VALUE_RESET      = 8'h00;
   localparam int unsigned STAT_BUSY_BIT    = 0;
   localparam int unsigned STAT_DRIVE_BIT   = 1;
   localparam int unsigned STAT_VALID_BIT   = 2;

   // ==========================================================
   // AHB-Lite encodings
   // ==========================================================
   localparam logic [2:0] HSIZE_BYTE = 3'h0;
   localparam logic [2:0] HSIZE_HALF = 3'h1;
   localparam logic       HRESP_OKAY = 1'b0;

   // ==========================================================
   // Timing: longest settling time, rounded down to cycles
   // ==========================================================
   localparam int unsigned CONV_TIME_NS  = 3000;
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned CONV_CYC_RAW  = CONV_TIME_NS / CLK_PERIOD_NS;
   localparam logic [7:0]  CONV_CYC      =
      8'((CONV_CYC_RAW < 1) ? 1 : CONV_CYC_RAW);

   // Converter states, Gray coded along off -> settle -> hold
   typedef enum logic [1:0] {
      DTC_OFF    = 2'b00,
      DTC_SETTLE = 2'b01,
      DTC_HOLD   = 2'b11
   } dtc_conv_state_e;

endpackage

//--- pkg/dtc_conv_if.sv
// Carrier between the register front end and the converter core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface dtc_conv_if;
   logic       start;     // One-cycle conversion start
   logic [7:0] code;      // Code to convert, valid with start
   logic       enable;    // Conversion enable level
   logic       stop;      // Deep stop standby level
   logic [7:0] level;     // Code on the ladder
   logic       drive_n;   // Low while the pin is driven
   logic       busy;      // Settling in progress
   logic       valid;     // Ladder holds a defined code

   modport ctl (output start, code, enable, stop,
                input  level, drive_n, busy, valid);
   modport cnv (input  start, code, enable, stop,
                output level, drive_n, busy, valid);
endinterface

//--- design/dtc_conv.sv
// Converter core: latches a code into the ladder and times settling.
// Assumes start arrives already qualified by the mode logic.
`timescale 1ns/1ps
module dtc_conv
   import dtc_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   dtc_conv_if.cnv  cif
);

   dtc_conv_state_e state_q, state_d;
   logic [7:0]      cnt_q, cnt_d;
   logic [7:0]      level_q, level_d;
   logic            busy_q, valid_q, drive_n_q;
   logic            run, take;

   // ==========================================================
   // Next state
   // ==========================================================
   // Stop freezes the core where it is; the pin is released below
   assign run  = cif.enable & ~cif.stop;
   assign take = cif.start & run;
   assign level_d = take ? cif.code : level_q;

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      unique case (state_q)
         DTC_OFF: begin
            if (take) state_d = DTC_SETTLE;
         end
         DTC_SETTLE: begin
            if (run && cnt_q == 8'h01) state_d = DTC_HOLD;
            if (run && cnt_q != 8'h00) cnt_d = cnt_q - 8'h01;
         end
         DTC_HOLD: begin
            if (take) state_d = DTC_SETTLE;
         end
         // Code 2'b10 is never entered; fall back to off if it appears
         default: begin
            state_d = DTC_OFF;
         end
      endcase
      if (take) begin
         state_d = DTC_SETTLE;
         cnt_d   = CONV_CYC;
      end
      // Clearing the enable is the only way to stop it outside stop mode
      if (!cif.enable) state_d = DTC_OFF;
   end

   // ==========================================================
   // State and outputs
   // ==========================================================
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q   <= DTC_OFF;
         cnt_q     <= 8'h00;
         level_q   <= VALUE_RESET;
         busy_q    <= 1'b0;
         valid_q   <= 1'b0;
         drive_n_q <= 1'b1;
      end else begin
         state_q   <= state_d;
         cnt_q     <= cnt_d;
         level_q   <= level_d;
         busy_q    <= (state_d == DTC_SETTLE);
         valid_q   <= (state_d != DTC_OFF);
         drive_n_q <= ~((state_d != DTC_OFF) & ~cif.stop);
      end
   end

   assign cif.level   = level_q;
   assign cif.busy    = busy_q;
   assign cif.valid   = valid_q;
   assign cif.drive_n = drive_n_q;

endmodule

//--- design/dtc_top.sv
// D/A trigger control: AHB-Lite register front end and trigger logic.
// Assumes the timer compare trigger is a one-cycle pulse on hclk and
// that the ladder itself turns dac_level into an analog level.
//
// Chosen here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module dtc_top
   import dtc_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        timer_compare_trigger,
   input  wire logic        stop_mode,
   output logic [7:0]       dac_level,
   output logic             analog_out_oe_n,
   output logic             conv_busy
);

   // ==========================================================
   // Declarations
   // ==========================================================
   dtc_conv_if cif ();

   logic [7:0]       mode_q, mode_d;
   logic [7:0]       value_q, value_d;
   logic [7:0]       code_q, code_d;
   logic             start_q, start_d;
   logic [31:0]      rdata_q, rdata_d;
   logic             dph_wr_q;
   logic [DEC_W-1:0] dph_addr_q;
   logic             dph_lane0_q;

   logic             aph_take;
   logic             aph_lane0;
   logic [DEC_W-1:0] aph_addr;
   logic             wr_mode;
   logic             wr_value;
   logic [7:0]       wr_byte;
   logic             ce_q, ce_d;
   logic             rt_q;
   logic             ce_rise;
   logic             norm_start;
   logic             rt_start;
   logic [7:0]       status_now;
   logic [7:0]       rsel_byte;

   // ==========================================================
   // Address phase
   // ==========================================================
   // A transfer is taken when selected, active and the bus is ready
   assign aph_take = hsel & hready & htrans[1];
   assign aph_addr = haddr[DEC_W-1:0];

   // Register bits live in byte lane 0; other lanes do not reach them
   assign aph_lane0 = (hsize == HSIZE_BYTE) ? (haddr[1:0] == 2'b00) :
                      (hsize == HSIZE_HALF) ? (haddr[1] == 1'b0) :
                      1'b1;

   // Capture the write so its data phase can commit next cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dph_wr_q    <= 1'b0;
         dph_addr_q  <= '0;
         dph_lane0_q <= 1'b0;
      end else begin
         dph_wr_q    <= aph_take & hwrite;
         dph_addr_q  <= aph_addr;
         dph_lane0_q <= aph_lane0;
      end
   end

   // ==========================================================
   // Data phase write decode
   // ==========================================================
   assign wr_byte  = hwdata[7:0];
   assign wr_mode  = dph_wr_q & dph_lane0_q
                     & (dph_addr_q == OFS_MODE_CONTROL);
   assign wr_value = dph_wr_q & dph_lane0_q
                     & (dph_addr_q == OFS_OUTPUT_VALUE);

   // Only the defined mode bits can be set; the rest read zero
   assign mode_d  = wr_mode ? (wr_byte & MODE_WR_MASK) : mode_q;
   assign value_d = wr_value ? wr_byte : value_q;

   // ==========================================================
   // Mode decode
   // ==========================================================
   assign ce_q = mode_q[MODE_CE_BIT];
   assign ce_d = mode_d[MODE_CE_BIT];
   assign rt_q = mode_q[MODE_RT_BIT];

   // Enabling in normal mode converts what is already in the register
   assign ce_rise = ce_d & ~ce_q & ~mode_d[MODE_RT_BIT];

   // Normal mode starts on value writes, never on the timer
   assign norm_start = ~rt_q & ce_q & wr_value;

   // Real-time mode starts only on the timer compare event
   assign rt_start = rt_q & ce_q & timer_compare_trigger;

   assign start_d = norm_start | rt_start | ce_rise;

   // A trigger samples the register as it stands before any write in
   // the same cycle lands; software is expected to avoid that clash
   assign code_d = rt_start             ? value_q :
                   (norm_start | ce_rise) ? value_d :
                   code_q;

   // ==========================================================
   // Register state
   // ==========================================================
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_q  <= MODE_RESET;
         value_q <= VALUE_RESET;
         code_q  <= VALUE_RESET;
         start_q <= 1'b0;
      end else begin
         mode_q  <= mode_d;
         value_q <= value_d;
         code_q  <= code_d;
         start_q <= start_d;
      end
   end

   // ==========================================================
   // Read path
   // ==========================================================
   // Status shows the core as it is now, not a latched copy
   assign status_now = {5'h00,
                        cif.valid,
                        ~cif.drive_n,
                        cif.busy};

   // Reads use the next values so a read right after a write sees it
   assign rsel_byte =
      (aph_addr == OFS_MODE_CONTROL) ? mode_d :
      (aph_addr == OFS_OUTPUT_VALUE) ? value_d :
      (aph_addr == OFS_STATUS)       ? status_now :
      8'h00;

   // Unmapped addresses and non-lane-0 reads answer zero
   assign rdata_d = (aph_take & ~hwrite) ?
                    {24'h000000, (aph_lane0 ? rsel_byte : 8'h00)} :
                    32'h00000000;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_q <= 32'h00000000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // Zero wait states: the slave never stretches a transfer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= HRESP_OKAY;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= HRESP_OKAY;
      end
   end

   assign hrdata = rdata_q;

   // ==========================================================
   // Converter core
   // ==========================================================
   assign cif.start  = start_q;
   assign cif.code   = code_q;
   assign cif.enable = ce_q;
   assign cif.stop   = stop_mode;

   dtc_conv u_conv (
      .hclk    (hclk),
      .hresetn (hresetn),
      .cif     (cif)
   );

   // ==========================================================
   // Pin side outputs, each from a core flip-flop
   // ==========================================================
   // The ladder code and pin enable leave straight from the core
   assign dac_level       = cif.level;
   assign analog_out_oe_n = cif.drive_n;
   assign conv_busy       = cif.busy;

endmodule

//--- verification/dtc_top_assertions.sv
// Checker for dtc_top: bus answer, start timing and pin enable.
// Assumes lane-0 register writes and a single bus slave.
`timescale 1ns/1ps
module dtc_top_assertions
   import dtc_pkg::*;
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic        timer_compare_trigger,
   input wire logic        stop_mode,
   input wire logic [7:0]  dac_level,
   input wire logic        analog_out_oe_n,
   input wire logic        conv_busy
);
   // ==========
   // Register shadows, rebuilt from bus traffic
   logic       wr_q;
   logic [7:0] adr_q;
   logic [7:0] mode_q;
   logic [7:0] val_q;
   logic       lane0;
   logic       wm;
   logic       wv;
   logic       rt;
   logic       en;
   // Upper lanes never reach the registers
   assign lane0 = hsize == 3'h2 || (hsize == HSIZE_BYTE && haddr[1:0] == 2'h0)
                  || (hsize == HSIZE_HALF && !haddr[1]);
   assign wm = wr_q && adr_q == OFS_MODE_CONTROL;
   assign wv = wr_q && adr_q == OFS_OUTPUT_VALUE;
   assign rt = mode_q[MODE_RT_BIT];
   assign en = mode_q[MODE_CE_BIT];
   // Shadows load on the data-phase edge, as the registers do
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q   <= 1'b0;
         adr_q  <= 8'h00;
         mode_q <= MODE_RESET;
         val_q  <= VALUE_RESET;
      end else begin
         wr_q  <= hsel && hready && htrans[1] && hwrite && lane0;
         adr_q <= haddr[7:0];
         if (wm) begin
            mode_q <= hwdata[7:0] & MODE_WR_MASK;
         end
         if (wv) begin
            val_q <= hwdata[7:0];
         end
      end
   end
   // ==========
   // Properties
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_bus;
      hreadyout && hresp == HRESP_OKAY && hrdata[31:8] == 24'h0;
   endproperty
   a_bus: assert property (p_bus) else $error("bus answer wrong");
   property p_norm_wr;
      wv && !rt && en && !stop_mode |->
         ##2 dac_level == $past(hwdata[7:0], 2) && conv_busy && !analog_out_oe_n;
   endproperty
   a_norm_wr: assert property (p_norm_wr) else $error("write did not convert");
   property p_rt_wr;
      wv && rt && en && !timer_compare_trigger && !$past(timer_compare_trigger)
         |-> ##2 $stable(dac_level);
   endproperty
   a_rt_wr: assert property (p_rt_wr) else $error("write converted in rt");
   property p_trig;
      timer_compare_trigger && rt && en && !stop_mode |->
         ##2 dac_level == $past(val_q, 2) && !analog_out_oe_n;
   endproperty
   a_trig: assert property (p_trig) else $error("trigger load wrong");
   property p_dis;
      !en [*3] |-> $stable(dac_level);
   endproperty
   a_dis: assert property (p_dis) else $error("level moved while off");
   property p_en_drive;
      wm && !en && hwdata[MODE_CE_BIT] && !hwdata[MODE_RT_BIT] && !stop_mode |->
         ##2 dac_level == $past(val_q, 2) && !analog_out_oe_n;
   endproperty
   a_en_drive: assert property (p_en_drive) else $error("enable did not drive");
   property p_rt_undef;
      wm && !en && analog_out_oe_n && hwdata[7:0] == 8'h81 |-> ##1 analog_out_oe_n [*2];
   endproperty
   a_rt_undef: assert property (p_rt_undef) else $error("pin driven early");
   property p_stop;
      stop_mode |=> analog_out_oe_n;
   endproperty
   a_stop: assert property (p_stop) else $error("pin driven in stop");
   property p_clr;
      wm && !hwdata[MODE_CE_BIT] |-> ##3 analog_out_oe_n && !conv_busy;
   endproperty
   a_clr: assert property (p_clr) else $error("clear did not stop");
   c_trig: cover property (timer_compare_trigger && rt && en);
   c_norm: cover property (wv && !rt && en);
   c_stop: cover property (stop_mode && !analog_out_oe_n);
endmodule

bind dtc_top dtc_top_assertions u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
   .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .timer_compare_trigger,
   .stop_mode, .dac_level, .analog_out_oe_n, .conv_busy);

//--- verification/dtc_top_tb.sv
// Self-checking bench for dtc_top over AHB-Lite and the trigger.
// Assumes one slave, so hready is fed back from hreadyout.
`timescale 1ns/1ps
module dtc_top_tb;
   import dtc_pkg::*;
   localparam logic [2:0] WORD = 3'h2;
   logic        hclk, hresetn, hsel, hwrite, trig, stop_mode;
   logic        hreadyout, hresp, analog_out_oe_n, conv_busy;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  dac_level;
   logic [31:0] haddr, hwdata, hrdata, rd;
   int          fail_count, n_checks;

   dtc_top DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .timer_compare_trigger(trig),
      .stop_mode, .dac_level, .analog_out_oe_n, .conv_busy);

   // ==========
   // Clock and shared tasks
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask
   // Single transfer; each phase holds until hready, under a bound
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                       input logic [2:0] sz);
      int n;
      n = 0;
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= w;
      hsize  <= sz;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 40);
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 40);
      rd = hrdata;
      if (n >= 40) begin
         fail_count++;
         print_verdict();
      end
   endtask
   // Trigger pulse, then time for the load to land
   task automatic pulse();
      trig <= 1'b1;
      @(posedge hclk);
      trig <= 1'b0;
      cyc(3);
   endtask

   // ==========
   // Scenarios
   task automatic t_reset();
      xfer(1'b0, OFS_MODE_CONTROL, 8'h00, WORD);
      chk(rd, 32'h0);
      xfer(1'b0, OFS_OUTPUT_VALUE, 8'h00, WORD);
      chk(rd, 32'h0);
      xfer(1'b1, 8'h0c, 8'hff, WORD);
      xfer(1'b0, 8'h0c, 8'h00, WORD);
      chk(rd, 32'h0);
   endtask
   task automatic t_normal();
      int n;
      xfer(1'b1, OFS_MODE_CONTROL, 8'h00, WORD);
      xfer(1'b1, OFS_OUTPUT_VALUE, 8'h5a, WORD);
      cyc(4);
      chk({dac_level, analog_out_oe_n}, {8'h00, 1'b1});
      xfer(1'b1, OFS_MODE_CONTROL, 8'h80, WORD);
      n = 0;
      cyc(1);
      do begin
         @(posedge hclk);
         n++;
      // Shared port data stays untouched until settling ends
      end while (conv_busy === 1'b1 && n < 200);
      chk(32'(n), 32'(CONV_CYC) + 32'h1);
      chk({dac_level, analog_out_oe_n}, {8'h5a, 1'b0});
      xfer(1'b1, OFS_OUTPUT_VALUE, 8'hff, WORD);
      cyc(4);
      chk(dac_level, 8'hff);
      xfer(1'b1, OFS_OUTPUT_VALUE, 8'h3c, WORD);
      xfer(1'b1, OFS_OUTPUT_VALUE, 8'h00, WORD);
      cyc(4);
      chk(dac_level, 8'h00);
   endtask
   task automatic t_realtime();
      xfer(1'b1, OFS_MODE_CONTROL, 8'h01, WORD);
      xfer(1'b0, OFS_MODE_CONTROL, 8'h00, WORD);
      chk(rd, 32'h01);
      xfer(1'b1, OFS_OUTPUT_VALUE, 8'h44, WORD);
      xfer(1'b1, OFS_MODE_CONTROL, 8'h81, HSIZE_BYTE);
      cyc(4);
      chk({dac_level, analog_out_oe_n}, {8'h00, 1'b1});
      xfer(1'b0, OFS_STATUS, 8'h00, WORD);
      chk(rd, 32'h00);
      pulse();
      chk({dac_level, analog_out_oe_n}, {8'h44, 1'b0});
      xfer(1'b0, OFS_STATUS, 8'h00, WORD);
      chk(rd, 32'h07);
      // Next value goes in well clear of any trigger
      xfer(1'b1, OFS_OUTPUT_VALUE, 8'h55, HSIZE_BYTE);
      cyc(4);
      chk(dac_level, 8'h44);
      pulse();
      chk(dac_level, 8'h55);
      xfer(1'b0, OFS_MODE_CONTROL, 8'h00, HSIZE_BYTE);
      chk(rd, 32'h81);
   endtask
   task automatic t_disable();
      xfer(1'b1, OFS_MODE_CONTROL, 8'h01, WORD);
      cyc(4);
      chk({conv_busy, analog_out_oe_n}, {1'b0, 1'b1});
      pulse();
      xfer(1'b1, OFS_OUTPUT_VALUE, 8'h12, WORD);
      cyc(4);
      chk(dac_level, 8'h55);
   endtask
   task automatic t_stop();
      xfer(1'b1, OFS_MODE_CONTROL, 8'h80, WORD);
      cyc(4);
      chk({dac_level, analog_out_oe_n}, {8'h12, 1'b0});
      stop_mode <= 1'b1;
      cyc(2);
      chk(analog_out_oe_n, 1'b1);
      stop_mode <= 1'b0;
      cyc(4);
      chk({dac_level, analog_out_oe_n}, {8'h12, 1'b0});
   endtask

   // ==========
   // Main sequence
   initial begin
      hresetn    = 1'b0;
      hsel       = 1'b0;
      haddr      = 32'h0;
      htrans     = 2'h0;
      hwrite     = 1'b0;
      hsize      = WORD;
      hwdata     = 32'h0;
      trig       = 1'b0;
      stop_mode  = 1'b0;
      fail_count = 0;
      n_checks   = 0;
      cyc(6);
      // The shared pin is taken as already in input mode
      hresetn <= 1'b1;
      t_reset();
      t_normal();
      t_realtime();
      t_disable();
      t_stop();
      print_verdict();
   end
endmodule
